// *** shared/npe_pkg.sv ***
// constants and types shared by the nand page ecc engine
package npe_pkg;

  // register byte offsets on the bus
  localparam logic [7:0] NPE_OFF_CTRL    = 8'h00;
  localparam logic [7:0] NPE_OFF_MODE    = 8'h04;
  localparam logic [7:0] NPE_OFF_FLAGS_A = 8'h08;
  localparam logic [7:0] NPE_OFF_PAR0    = 8'h0C;
  localparam logic [7:0] NPE_OFF_PAR1    = 8'h10;
  localparam logic [7:0] NPE_OFF_FLAGS_B = 8'h14;
  localparam logic [7:0] NPE_OFF_PAR2    = 8'h18;
  localparam logic [7:0] NPE_OFF_PAR15   = 8'h4C;

  // control and mode field positions
  localparam int NPE_CR_PAR_RST  = 0;
  localparam int NPE_CR_SOFT_RST = 1;
  localparam int NPE_MR_PAGE_LSB = 0;
  localparam int NPE_MR_GRAN_LSB = 4;
  localparam logic [1:0] NPE_MODE_RST = 2'h0;

  // flag nibble layout per sector
  localparam int NPE_FL_REC = 0;
  localparam int NPE_FL_ECC = 1;
  localparam int NPE_FL_MUL = 2;

  // flash command codes that start a page computation
  localparam logic [7:0] NPE_CMD_READ = 8'h00;
  localparam logic [7:0] NPE_CMD_PROG = 8'h80;

  // correction granularity encodings
  localparam logic [1:0] NPE_GRAN_PAGE = 2'h0;
  localparam logic [1:0] NPE_GRAN_256  = 2'h1;
  localparam logic [1:0] NPE_GRAN_512  = 2'h2;

  // sizes as log2 of word counts
  localparam logic [3:0] NPE_MAIN_LOG2_MIN = 4'h9;
  localparam logic [3:0] NPE_SEC256_LOG2   = 4'h8;
  localparam logic [3:0] NPE_SEC512_LOG2   = 4'h9;

  // code layout: low half parity, high half inverted parity
  localparam int NPE_ROW_LSB  = 4;
  localparam int NPE_ROW_BITS = 12;
  localparam int NPE_COL_BITS = 4;
  localparam logic [3:0][15:0] NPE_COL_MASK = {16'hFF00, 16'hF0F0, 16'hCCCC, 16'hAAAA};
  localparam logic [15:0] NPE_BYTE_MASK = 16'h00FF;
  localparam logic [15:0] NPE_WORD_MASK = 16'hFFFF;
  localparam logic [1:0]  NPE_SP_LAST_8  = 2'h3;
  localparam logic [1:0]  NPE_SP_LAST_16 = 2'h1;

  // bus response codes
  localparam logic [1:0] NPE_RESP_OKAY   = 2'h0;
  localparam logic [1:0] NPE_RESP_SLVERR = 2'h2;

  // page tracking states, gray along idle-cmd-addr-data-spare-done
  typedef enum logic [2:0] {
    NPE_IDLE  = 3'h0,
    NPE_CMD   = 3'h1,
    NPE_ADDR  = 3'h3,
    NPE_DATA  = 3'h2,
    NPE_SPARE = 3'h6,
    NPE_DONE  = 3'h4
  } npe_state_t;

endpackage : npe_pkg

// *** hdl/npe_nand_page_ecc.sv ***
// nand page ecc engine: flash bus monitor, parity, checker and register slave
//
// Added by the designer: the address map and register access over AXI4-Lite.
`timescale 1ns/1ns

module npe_nand_page_ecc
  import npe_pkg::*;
#(
  parameter int NUM_SECTORS = 16            // parity registers available
) (
  input  wire logic        ref_clk,          // system clock
  input  wire logic        sys_rst,          // synchronous reset, active high
  input  wire logic        flash_cle,        // command latch enable seen on the bus
  input  wire logic        flash_ale,        // address latch enable seen on the bus
  input  wire logic        flash_wr_stb,     // one-cycle write strobe to the flash
  input  wire logic        flash_rd_stb,     // one-cycle read strobe from the flash
  input  wire logic [15:0] flash_data,       // flash data bus as sampled
  input  wire logic        flash_wide,       // high for 16-bit flash organisation
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);

  // whole state of the block
  typedef struct packed {
    npe_state_t       st;        // page tracking state
    logic             is_read;   // page read rather than program
    logic [12:0]      cnt;       // main-area word counter
    logic [3:0]       sec;       // sector being accumulated
    logic [15:0]      acc_p;     // running parity
    logic [15:0]      acc_n;     // running inverted parity
    logic [1:0]       sp_cnt;    // spare units gathered for this code
    logic [3:0]       sp_sec;    // sector whose stored code is gathered
    logic [31:0]      stored;    // stored code shift register
    logic [15:0][31:0] code;     // parity results per sector
    logic [15:0][2:0] flags;     // {mul, ecc, rec} per sector
    logic [1:0]       page_sel;  // page_words_sel
    logic [1:0]       gran;      // correction_granularity
    logic             aw_have;   // write address held
    logic [7:0]       awaddr;
    logic             w_have;    // write data held
    logic [31:0]      wdata;
    logic [3:0]       wstrb;
    logic             bvalid;
    logic [1:0]       bresp;
    logic             rvalid;
    logic [31:0]      rdata;
    logic [1:0]       rresp;
  } npe_regs_t;

  npe_regs_t q;                  // registered state
  npe_regs_t d;                  // next state

  // log2 of words per code: sector size only for 8-bit flash
  function automatic logic [3:0] sec_log2(input logic [1:0] pg, input logic [1:0] gr,
                                          input logic wd);
    logic [3:0] m;
    m = NPE_MAIN_LOG2_MIN + {2'h0, pg};
    if (!wd && gr == NPE_GRAN_256) begin
      sec_log2 = NPE_SEC256_LOG2;
    end else if (!wd && gr == NPE_GRAN_512) begin
      sec_log2 = NPE_SEC512_LOG2;
    end else begin
      sec_log2 = m;
    end
  endfunction : sec_log2

  // code bits that carry meaning for a given sector size and width
  function automatic logic [15:0] code_mask(input logic [3:0] sl, input logic wd);
    code_mask = '0;
    for (int i = 0; i < NPE_ROW_BITS; i++) begin
      code_mask[NPE_ROW_LSB + i] = (i < int'(sl));
    end
    code_mask[NPE_COL_BITS-1:0] = wd ? 4'hF : 4'h7;
  endfunction : code_mask

  // parity register offset to sector index, msb flags a hit
  function automatic logic [4:0] par_index(input logic [7:0] a);
    logic [7:0] k;
    k = (a - NPE_OFF_PAR2) >> 2;
    if (a == NPE_OFF_PAR0) begin
      par_index = 5'h10;
    end else if (a == NPE_OFF_PAR1) begin
      par_index = 5'h11;
    end else if (a >= NPE_OFF_PAR2 && a <= NPE_OFF_PAR15 && a[1:0] == 2'h0) begin
      par_index = {1'b1, 4'(k + 8'h02)};
    end else begin
      par_index = 5'h00;
    end
  endfunction : par_index

  // true for any mapped register offset
  function automatic logic reg_known(input logic [7:0] a);
    reg_known = (a == NPE_OFF_CTRL) || (a == NPE_OFF_MODE) || (a == NPE_OFF_FLAGS_A) ||
                (a == NPE_OFF_FLAGS_B) || (par_index(a) >= 5'h10);
  endfunction : reg_known

  // read data for one register; flags pack as nibbles, bit 3 reads zero
  function automatic logic [31:0] rd_word(input npe_regs_t r, input logic [7:0] a);
    logic [4:0] pi;
    pi = par_index(a);
    rd_word = '0;
    if (a == NPE_OFF_MODE) begin
      rd_word[NPE_MR_PAGE_LSB +: 2] = r.page_sel;
      rd_word[NPE_MR_GRAN_LSB +: 2] = r.gran;
    end else if (a == NPE_OFF_FLAGS_A || a == NPE_OFF_FLAGS_B) begin
      for (int s = 0; s < 8; s++) begin
        rd_word[4*s +: 3] = (a == NPE_OFF_FLAGS_A) ? r.flags[s] : r.flags[s + 8];
      end
    end else if (pi[4] && int'(pi[3:0]) < NUM_SECTORS) begin
      rd_word = r.code[pi[3:0]];
    end
  endfunction : rd_word

  // derived values for the page in flight
  logic        do_wr;            // a complete register write is performed
  logic        par_clr;          // write-one parity clear
  logic        soft_clr;         // write-one block soft reset
  logic        data_cyc;         // neither latch enable asserted
  logic        take;             // a main-area word is taken
  logic [15:0] dmask;            // bits valid in a word
  logic [15:0] dat;              // word with unused lanes removed
  logic        wx;               // parity of all bits of the word
  logic [3:0]  slog;             // log2 words per code
  logic [3:0]  mlog;             // log2 main-area words
  logic [12:0] sec_mask;         // word index bits within a sector
  logic [12:0] row;              // word index within the sector
  logic [3:0]  last_sec;         // index of the final sector
  logic [15:0] cmask;            // meaningful code bits
  logic [31:0] stored_n;         // stored code including this unit
  logic [31:0] syn;              // masked syndrome
  logic [15:0] loc;              // failing position from parity half

  assign dmask    = flash_wide ? NPE_WORD_MASK : NPE_BYTE_MASK;
  assign dat      = flash_data & dmask;
  assign wx       = ^dat;
  assign slog     = sec_log2(q.page_sel, q.gran, flash_wide);
  assign mlog     = NPE_MAIN_LOG2_MIN + {2'h0, q.page_sel};
  assign sec_mask = (13'h1 << slog) - 13'h1;
  assign row      = q.cnt & sec_mask;
  assign last_sec = 4'((16'h1 << (mlog - slog)) - 16'h1);
  assign cmask    = code_mask(slog, flash_wide);
  assign data_cyc = !flash_cle && !flash_ale;
  assign take     = data_cyc && (q.is_read ? flash_rd_stb : flash_wr_stb) &&
                    (q.st == NPE_ADDR || q.st == NPE_DATA);
  assign stored_n = flash_wide ? {dat, q.stored[31:16]} : {dat[7:0], q.stored[31:8]};
  assign syn      = (q.code[q.sp_sec] ^ stored_n) & {cmask, cmask};
  assign loc      = (q.code[q.sp_sec][15:0] ^ stored_n[15:0]) & cmask;

  // bus handshakes come straight from the holding flags
  assign s_axi_awready = !q.aw_have;
  assign s_axi_wready  = !q.w_have;
  assign s_axi_arready = !q.rvalid;
  assign s_axi_bvalid  = q.bvalid;
  assign s_axi_bresp   = q.bresp;
  assign s_axi_rvalid  = q.rvalid;
  assign s_axi_rdata   = q.rdata;
  assign s_axi_rresp   = q.rresp;

  // next-state logic: bus slave first, then clears, then hardware sets so sets win
  always_comb begin
    d        = q;
    do_wr    = 1'b0;
    par_clr  = 1'b0;
    soft_clr = 1'b0;

    // address and data are taken in either order and held until paired
    if (s_axi_awvalid && !q.aw_have) begin
      d.aw_have = 1'b1;
      d.awaddr  = s_axi_awaddr;
    end
    if (s_axi_wvalid && !q.w_have) begin
      d.w_have = 1'b1;
      d.wdata  = s_axi_wdata;
      d.wstrb  = s_axi_wstrb;
    end
    if (q.bvalid && s_axi_bready) begin
      d.bvalid = 1'b0;
    end
    // one write performed per response; a pending response stalls the next
    if (q.aw_have && q.w_have && !q.bvalid) begin
      do_wr     = 1'b1;
      d.aw_have = 1'b0;
      d.w_have  = 1'b0;
      d.bvalid  = 1'b1;
      d.bresp   = reg_known(q.awaddr) ? NPE_RESP_OKAY : NPE_RESP_SLVERR;
    end
    if (do_wr && q.wstrb[0] && q.awaddr == NPE_OFF_CTRL) begin
      par_clr  = q.wdata[NPE_CR_PAR_RST];
      soft_clr = q.wdata[NPE_CR_SOFT_RST];
    end
    if (do_wr && q.wstrb[0] && q.awaddr == NPE_OFF_MODE) begin
      d.page_sel = q.wdata[NPE_MR_PAGE_LSB +: 2];
      d.gran     = q.wdata[NPE_MR_GRAN_LSB +: 2];
    end

    // read answers one cycle after the address is taken
    if (q.rvalid && s_axi_rready) begin
      d.rvalid = 1'b0;
    end
    if (s_axi_arvalid && !q.rvalid) begin
      d.rvalid = 1'b1;
      d.rdata  = rd_word(q, s_axi_araddr);
      d.rresp  = reg_known(s_axi_araddr) ? NPE_RESP_OKAY : NPE_RESP_SLVERR;
    end

    // software clears; a soft reset also drops the mode and the page in flight
    if (soft_clr) begin
      d.st       = NPE_IDLE;
      d.flags    = '0;
      d.code     = '0;
      d.page_sel = NPE_MODE_RST;
      d.gran     = NPE_MODE_RST;
      d.acc_p    = '0;
      d.acc_n    = '0;
    end
    if (par_clr) begin
      d.code = '0;
    end

    // command latch: only read and program restart the engine
    if (flash_wr_stb && flash_cle) begin
      if (dat[7:0] == NPE_CMD_READ || dat[7:0] == NPE_CMD_PROG) begin
        d.st      = NPE_CMD;
        d.is_read = (dat[7:0] == NPE_CMD_READ);
        d.cnt     = '0;
        d.sec     = '0;
        d.acc_p   = '0;
        d.acc_n   = '0;
        d.sp_cnt  = '0;
        d.sp_sec  = '0;
        d.code    = '0;
        d.flags   = '0;
      end
    end else if (flash_wr_stb && flash_ale) begin
      // address cycles arm counting; stray addresses elsewhere are ignored
      if (q.st == NPE_CMD || q.st == NPE_ADDR) begin
        d.st = NPE_ADDR;
      end
    end else if (take) begin
      // first data cycle after the address opens the main area at word 0
      d.st = NPE_DATA;
      for (int i = 0; i < NPE_ROW_BITS; i++) begin
        if (i < int'(slog)) begin
          if (row[i]) begin
            d.acc_p[NPE_ROW_LSB + i] = q.acc_p[NPE_ROW_LSB + i] ^ wx;
          end else begin
            d.acc_n[NPE_ROW_LSB + i] = q.acc_n[NPE_ROW_LSB + i] ^ wx;
          end
        end
      end
      for (int k = 0; k < NPE_COL_BITS; k++) begin
        d.acc_p[k] = q.acc_p[k] ^ (^(dat & NPE_COL_MASK[k]));
        d.acc_n[k] = q.acc_n[k] ^ (^(dat & ~NPE_COL_MASK[k] & dmask));
      end
      d.cnt = q.cnt + 13'h1;
      // sector complete: bank its code, unused bits forced to zero, start the next
      if (row == sec_mask) begin
        if (int'(q.sec) < NUM_SECTORS) begin
          d.code[q.sec] = {d.acc_n & cmask, d.acc_p & cmask};
        end
        d.acc_p = '0;
        d.acc_n = '0;
        d.sec   = q.sec + 4'h1;
      end
      // end of main area: program results valid and frozen; reads go on to the spare area
      if (row == sec_mask && q.sec == last_sec) begin
        d.st = q.is_read ? NPE_SPARE : NPE_DONE;
      end
    end else if (data_cyc && flash_rd_stb && q.st == NPE_SPARE) begin
      // stored codes follow the main area, low byte of parity first
      d.stored = stored_n;
      d.sp_cnt = q.sp_cnt + 2'h1;
      if (q.sp_cnt == (flash_wide ? NPE_SP_LAST_16 : NPE_SP_LAST_8)) begin
        d.sp_cnt = '0;
        d.sp_sec = q.sp_sec + 4'h1;
        if (q.sp_sec == last_sec) begin
          d.st = NPE_DONE;
        end
        if (syn == 32'h0) begin
          d.flags[q.sp_sec] = 3'h0;
        end else if ((syn[15:0] ^ syn[31:16]) == cmask) begin
          // every pair disagrees once: one data bit, located by parity half
          d.flags[q.sp_sec]             = 3'h0;
          d.flags[q.sp_sec][NPE_FL_REC] = 1'b1;
          d.code[q.sp_sec]              = {16'h0, loc};
        end else if ($countones(syn) == 1) begin
          d.flags[q.sp_sec]             = 3'h0;
          d.flags[q.sp_sec][NPE_FL_ECC] = 1'b1;
        end else begin
          // double and worse errors cannot be located
          d.flags[q.sp_sec]             = 3'h0;
          d.flags[q.sp_sec][NPE_FL_MUL] = 1'b1;
          d.flags[q.sp_sec][NPE_FL_REC] = 1'b1;
        end
      end
    end
  end

  // single register stage for the whole state
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

endmodule : npe_nand_page_ecc

// *** testbench/npe_monitor.sv ***
// register bus assertions for the nand page ecc engine
`timescale 1ns/1ns
module npe_monitor
  import npe_pkg::*;
(
  input wire logic        ref_clk,
  input wire logic        sys_rst,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready
);
  logic [7:0] ar_q;  // register that the pending read answers for
  // capture the read address; no reset needed, rvalid gates its use
  always_ff @(posedge ref_clk) begin
    if (s_axi_arvalid && s_axi_arready) begin
      ar_q <= s_axi_araddr;
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  a_write_answer: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && !s_axi_bvalid
    |-> ##2 s_axi_bvalid) else $error("write response missing");
  a_bresp_stands: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  a_addr_refused: assert property (
    s_axi_awvalid && s_axi_awready |=> !s_axi_awready) else $error("address not held");
  a_data_refused: assert property (
    s_axi_wvalid && s_axi_wready |=> !s_axi_wready) else $error("data not held");
  a_read_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read answer missing");
  a_rdata_stands: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata)
    && $stable(s_axi_rresp)) else $error("read data changed while waiting");
  a_read_refused: assert property (
    s_axi_rvalid |-> !s_axi_arready) else $error("read taken while busy");
  a_rvalid_drops: assert property (
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid) else $error("read answer repeated");
  a_ctrl_reads_zero: assert property (
    s_axi_rvalid && ar_q == NPE_OFF_CTRL |-> s_axi_rdata == 32'h00000000)
    else $error("control register not write-only");
  a_unmapped_err: assert property (
    s_axi_rvalid && ar_q > NPE_OFF_PAR15 |-> s_axi_rresp == NPE_RESP_SLVERR)
    else $error("unmapped read not refused");
  a_flag_gap_zero: assert property (
    s_axi_rvalid && ar_q == NPE_OFF_FLAGS_A |-> (s_axi_rdata & 32'h88888888) == 0)
    else $error("unused flag bit set");
  c_write: cover property (s_axi_bvalid && s_axi_bready);
  c_flags: cover property (s_axi_rvalid && ar_q == NPE_OFF_FLAGS_A && s_axi_rdata != 0);
  c_slverr: cover property (s_axi_rvalid && s_axi_rresp == NPE_RESP_SLVERR);
endmodule : npe_monitor

bind npe_nand_page_ecc npe_monitor npe_monitor_i (.ref_clk(ref_clk), .sys_rst(sys_rst),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready));

// *** testbench/npe_flash_model.sv ***
// behavioural nand flash holding one page for the ecc bench
`timescale 1ns/1ns
module npe_flash_model (
  input  wire logic        ref_clk,  // bus clock
  input  wire logic        cle,      // command latch
  input  wire logic        ale,      // address latch
  input  wire logic        wr_stb,   // host write strobe
  input  wire logic        rd_stb,   // host read strobe
  input  wire logic [7:0]  din,      // byte written by the host
  output logic      [15:0] dout      // served byte, junk when idle
);
  logic [7:0]  mem [0:527];          // main area plus spare
  logic [9:0]  col_q  = 10'h000;     // column pointer
  logic [15:0] last_q = 16'hA5A5;    // last value driven
  // idle lines show the inverse of the last value so nothing stale passes
  assign dout = rd_stb ? {~last_q[15:8], mem[col_q]} : ~last_q;
  // plain always: the bench plants faults into mem by reference
  always @(posedge ref_clk) begin
    if (wr_stb && cle) begin
      col_q <= 10'h000;
    end else if (wr_stb && !ale) begin
      mem[col_q] <= din;
      col_q <= col_q + 10'h001;
    end else if (rd_stb) begin
      last_q <= dout;
      col_q <= col_q + 10'h001;
    end
  end
endmodule : npe_flash_model

// *** testbench/npe_nand_page_ecc_tb.sv ***
// self-checking bench for the nand page ecc engine
`timescale 1ns/1ns
module npe_nand_page_ecc_tb;
  import npe_pkg::*;
  localparam int LIMIT = 40000;           // cycle ceiling for the run
  logic        ref_clk, sys_rst;          // clock, reset
  logic        wide;                      // 16-bit flash organisation
  logic        cle, ale, wr_stb, rd_stb;  // host side of the flash bus
  logic [7:0]  host_byte;                 // byte the host drives
  logic [15:0] fl_dout, flash_data;       // flash output, shared lines
  logic [7:0]  awaddr, araddr;            // bus addresses
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata;              // bus data
  logic [1:0]  bresp, rresp;              // bus responses
  logic [7:0]  pg [0:527];                // page image kept by the host
  int          miscompares, checks, cycles;
  // the flash owns the lines only while it is read
  assign flash_data = rd_stb ? fl_dout : {8'h00, host_byte};
  npe_nand_page_ecc npe_nand_page_ecc_i (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .flash_cle(cle), .flash_ale(ale),
    .flash_wr_stb(wr_stb), .flash_rd_stb(rd_stb), .flash_data(flash_data),
    .flash_wide(wide), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  npe_flash_model npe_flash_model_i (.ref_clk(ref_clk), .cle(cle), .ale(ale),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .din(host_byte), .dout(fl_dout));
  // 100 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // a hang counts as a mismatch and ends the run
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      miscompares = miscompares + 1;
      test_done();
    end
  end
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checks = checks + 1;
    if (got !== exp) begin
      miscompares = miscompares + 1;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic test_done;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : test_done
  // one bus write; each channel released when taken, response awaited
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge ref_clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(posedge ref_clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid && bready) break;
    end
    bready <= 1'b0;
    chk("bresp", {30'h0, bresp}, {30'h0, er});
  endtask : wr
  // one bus read compared with response, and with data when an okay response is expected
  task automatic rc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    @(posedge ref_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge ref_clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid && rready) break;
    end
    rready <= 1'b0;
    chk("rresp", {30'h0, rresp}, {30'h0, er});
    if (er == NPE_RESP_OKAY) chk("rdata", rdata, e);
  endtask : rc
  // one flash write cycle, strobe low again before the next
  task automatic fl_wr(input logic c, input logic l, input logic [7:0] b);
    @(posedge ref_clk);
    cle <= c;
    ale <= l;
    host_byte <= b;
    wr_stb <= 1'b1;
    @(posedge ref_clk);
    {cle, ale, wr_stb} <= 3'b000;
  endtask : fl_wr
  // command, one address cycle, then n data cycles from column zero
  task automatic page(input logic [7:0] cmd, input int n);
    fl_wr(1'b1, 1'b0, cmd);
    fl_wr(1'b0, 1'b1, 8'h00);
    for (int j = 0; j < n; j++) begin
      if (cmd == NPE_CMD_READ) begin
        @(posedge ref_clk) rd_stb <= 1'b1;
        @(posedge ref_clk) rd_stb <= 1'b0;
      end else fl_wr(1'b0, 1'b0, pg[j]);
    end
  endtask : page
  // reference code: column pairs low bits, word index pairs above; w adds the upper byte pair
  function automatic logic [31:0] code(input int base, input int n, input int lg,
                                       input logic w);
    logic [15:0] p, q;
    logic [7:0]  d;
    p = 16'h0000;
    q = 16'h0000;
    for (int j = 0; j < n; j++) begin
      d = pg[base + j];
      for (int k = 0; k < (w ? 4 : 3); k++) begin
        p[k] ^= ^({8'h00, d} & NPE_COL_MASK[k]);
        q[k] ^= ^({8'h00, d} & ~NPE_COL_MASK[k]);
      end
      for (int i = 0; i < lg; i++) begin
        if (j[i]) p[NPE_ROW_LSB + i] ^= ^d;
        else q[NPE_ROW_LSB + i] ^= ^d;
      end
    end
    return {q, p};
  endfunction : code
  task automatic t_regs;
    rc(NPE_OFF_MODE, 32'h0, NPE_RESP_OKAY);
    rc(NPE_OFF_FLAGS_B, 32'h0, NPE_RESP_OKAY);
    rc(NPE_OFF_PAR15, 32'h0, NPE_RESP_OKAY);
    rc(8'h50, 32'h0, NPE_RESP_SLVERR);
    wr(8'h50, 32'h0, NPE_RESP_SLVERR);
    wr(NPE_OFF_FLAGS_A, 32'hFFFFFFFF, NPE_RESP_OKAY);
    rc(NPE_OFF_FLAGS_A, 32'h0, NPE_RESP_OKAY);
  endtask : t_regs
  task automatic t_prog(input logic [31:0] mode, input int lg, input logic w);
    logic [31:0] c0, c1;
    wr(NPE_OFF_MODE, mode, NPE_RESP_OKAY);
    wide <= w;
    for (int j = 0; j < 512; j++) pg[j] = 8'(j * 7) ^ 8'h5A;
    c0 = code(0, 1 << lg, lg, w);
    c1 = code(256, 256, lg, w);
    for (int b = 0; b < 8; b++) pg[512 + b] = b < 4 ? c0[8*b +: 8] : c1[8*b-32 +: 8];
    page(NPE_CMD_PROG, lg == 9 ? 516 : 520);
    rc(NPE_OFF_PAR0, c0, NPE_RESP_OKAY);
    if (lg == 8) rc(NPE_OFF_PAR1, c1, NPE_RESP_OKAY);
  endtask : t_prog
  // read the page back after planting faults, then heal the flash
  task automatic t_read(input int w0, input logic [7:0] m0, input int w1,
                        input logic [7:0] m1, input logic [31:0] fl);
    npe_flash_model_i.mem[w0] ^= m0;
    npe_flash_model_i.mem[w1] ^= m1;
    page(NPE_CMD_READ, 520);  // room for two stored codes; extra strobes are ignored
    rc(NPE_OFF_FLAGS_A, fl, NPE_RESP_OKAY);
    npe_flash_model_i.mem[w0] ^= m0;
    npe_flash_model_i.mem[w1] ^= m1;
  endtask : t_read
  task automatic t_clear;
    fl_wr(1'b1, 1'b0, 8'h30);
    rc(NPE_OFF_FLAGS_A, 32'h5, NPE_RESP_OKAY);
    fl_wr(1'b1, 1'b0, NPE_CMD_READ);
    rc(NPE_OFF_FLAGS_A, 32'h0, NPE_RESP_OKAY);
    rc(NPE_OFF_PAR0, 32'h0, NPE_RESP_OKAY);
    page(NPE_CMD_PROG, 516);
    wr(NPE_OFF_CTRL, 32'h1, NPE_RESP_OKAY);
    rc(NPE_OFF_PAR0, 32'h0, NPE_RESP_OKAY);
    wr(NPE_OFF_MODE, 32'h11, NPE_RESP_OKAY);
    rc(NPE_OFF_MODE, 32'h11, NPE_RESP_OKAY);
    wr(NPE_OFF_CTRL, 32'h2, NPE_RESP_OKAY);
    rc(NPE_OFF_MODE, 32'h0, NPE_RESP_OKAY);
    rc(NPE_OFF_CTRL, 32'h0, NPE_RESP_OKAY);
  endtask : t_clear
  initial begin
    {wide, cle, ale, wr_stb, rd_stb, awvalid, wvalid, bready, arvalid, rready} = 10'h000;
    {host_byte, awaddr, araddr, wdata} = 56'h0;
    miscompares = 0;
    checks = 0;
    cycles = 0;
    sys_rst = 1'b1;
    repeat (16) @(posedge ref_clk);
    sys_rst <= 1'b0;
    t_regs();
    t_prog(32'h00, 9, 1'b0);
    t_read(0, 8'h00, 0, 8'h00, 32'h0);
    t_read(37, 8'h20, 0, 8'h00, 32'h1);
    rc(NPE_OFF_PAR0, {16'h0, 12'd37, 4'd5}, NPE_RESP_OKAY);
    t_read(513, 8'h01, 0, 8'h00, 32'h2);
    t_read(3, 8'h01, 9, 8'h02, 32'h5);
    t_clear();
    t_prog(32'h10, 8, 1'b0);
    t_read(300, 8'h04, 0, 8'h00, 32'h10);
    rc(NPE_OFF_PAR1, {16'h0, 12'd44, 4'd2}, NPE_RESP_OKAY);
    // 16-bit words ignore the sector granularity and code the whole page
    t_prog(32'h20, 9, 1'b1);
    test_done();
  end
endmodule : npe_nand_page_ecc_tb
